// >>> rtl/mlc_mode_limit_ctrl.sv
//==============================================================
// Purpose: Mode and current-limit configuration with fault timing
// Assumes: Pins synchronous to core_clk; driver index 0 = C/Q, 1 = DO
// Notes:   Long timings are parameters so simulation can shorten them
//==============================================================
module mlc_mode_limit_ctrl
	import mlc_pkg::*;
#(
	parameter int BLANK0_CYC_P = mlc_pkg::BLANK0_CYC,
	parameter int BLANK1_CYC_P = mlc_pkg::BLANK1_CYC,
	parameter int BLANK2_CYC_P = mlc_pkg::BLANK2_CYC,
	parameter int BLANK3_CYC_P = mlc_pkg::BLANK3_CYC,
	parameter int RETRY0_CYC_P = mlc_pkg::RETRY0_CYC,
	parameter int RETRY1_CYC_P = mlc_pkg::RETRY1_CYC,
	parameter int RETRY2_CYC_P = mlc_pkg::RETRY2_CYC,
	parameter int RETRY3_CYC_P = mlc_pkg::RETRY3_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       csN,
	input  wire logic       sclk,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdoOe,
	output logic            irqN,
	input  wire logic       indicatorAInputPin,
	input  wire logic       fieldSupplyLow,
	input  wire logic [1:0] drvOverCurrent,
	input  wire logic [1:0] drvOverTemp,
	input  wire logic       dieCool,
	output logic            wakeupDetectOff,
	output logic            lowRailRegulatorOff,
	output logic            serialShareEnable,
	output logic            rxGlitchFilterOff,
	output logic            indicatorAOutput,
	output logic            indicatorBOutput,
	output logic [1:0]      limitSelect,
	output logic            limitOff,
	output logic [1:0]      driverEnable
);
	import mlc_pkg::*;

	mlc_reg_if regBus ();

	logic [7:0]       mode_r, mode_nxt;
	logic [7:0]       limit_r, limit_nxt;
	logic [7:0]       int_r, int_nxt;
	logic [7:0]       stat_r, stat_nxt;
	logic             irqN_r, irqN_nxt;
	logic [CNT_W-1:0] blankCnt_r [2];
	logic [CNT_W-1:0] blankCnt_nxt [2];
	logic [1:0]       faultHit;
	logic [CNT_W-1:0] blankLimit;
	logic [CNT_W-1:0] retryLimit;
	logic [CNT_W-1:0] offCnt_r, offCnt_nxt;
	mlc_drv_e         drvState_r, drvState_nxt;
	logic [1:0]       drvEn_r;
	logic [7:0]       outs_r, outs_nxt;
	logic             softRst;
	logic             autoRetry;

	//==========================================================
	// Serial register port
	mlc_serial_port uPort (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.csN      (csN),
		.sclk     (sclk),
		.sdi      (sdi),
		.sdo      (sdo),
		.sdoOe    (sdoOe),
		.regs     (regBus.port)
	);

	// Soft reset lasts the one cycle in which the bit reads one
	assign softRst   = mode_r[MODE_SOFT_RST];
	assign autoRetry = limit_r[RETRY_EN];

	//==========================================================
	// Read mux; reads never alter the configuration registers
	always_comb begin
		if (regBus.addr == ADDR_INT) begin
			regBus.rdData = int_r;
		end else if (regBus.addr == ADDR_STAT) begin
			regBus.rdData = stat_r;
		end else if (regBus.addr == ADDR_MODE) begin
			regBus.rdData = mode_r;
		end else if (regBus.addr == ADDR_LIMIT) begin
			regBus.rdData = limit_r;
		end else begin
			regBus.rdData = 8'h00;
		end
	end

	//==========================================================
	// Configuration registers
	// Writes during the soft-reset cycle are dropped so the bank
	// always lands on its defaults
	always_comb begin
		mode_nxt  = mode_r;
		limit_nxt = limit_r;
		if (softRst) begin
			mode_nxt  = REG_RESET;
			limit_nxt = REG_RESET;
		end else if (regBus.wrStb) begin
			if (regBus.addr == ADDR_MODE) begin
				mode_nxt = regBus.wrData;
			end else if (regBus.addr == ADDR_LIMIT) begin
				limit_nxt = regBus.wrData;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_r  <= REG_RESET;
			limit_r <= REG_RESET;
		end else begin
			mode_r  <= mode_nxt;
			limit_r <= limit_nxt;
		end
	end

	//==========================================================
	// Interrupt flags and status
	// A set in the read cycle wins, so no event is lost
	always_comb begin
		int_nxt = int_r;
		if (regBus.rdStb && regBus.addr == ADDR_INT) begin
			int_nxt = 8'h00;
		end
		int_nxt[INT_CQ_FAULT] = int_nxt[INT_CQ_FAULT]
			| faultHit[0];
		int_nxt[INT_DO_FAULT] = int_nxt[INT_DO_FAULT]
			| faultHit[1];
		int_nxt[INT_WARN] = int_nxt[INT_WARN]
			| (fieldSupplyLow & mode_r[MODE_WARN_EN]);
		stat_nxt = 8'h00;
		stat_nxt[STAT_THERMAL] = |drvOverTemp;
		stat_nxt[INT_CQ_FAULT] = drvOverCurrent[0] | drvOverTemp[0];
		stat_nxt[INT_DO_FAULT] = drvOverCurrent[1] | drvOverTemp[1];
		stat_nxt[INT_WARN]     = fieldSupplyLow;
		if (softRst) begin
			int_nxt  = 8'h00;
			stat_nxt = 8'h00;
		end
		irqN_nxt = ~(|int_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			int_r  <= 8'h00;
			stat_r <= 8'h00;
			irqN_r <= 1'b1;
		end else begin
			int_r  <= int_nxt;
			stat_r <= stat_nxt;
			irqN_r <= irqN_nxt;
		end
	end

	//==========================================================
	// Timing selects
	always_comb begin
		case (limit_r[BLANK_SEL_HI:BLANK_SEL_LO])
			2'b00:   blankLimit = CNT_W'(BLANK0_CYC_P);
			2'b01:   blankLimit = CNT_W'(BLANK1_CYC_P);
			2'b10:   blankLimit = CNT_W'(BLANK2_CYC_P);
			default: blankLimit = CNT_W'(BLANK3_CYC_P);
		endcase
		case (limit_r[RETRY_SEL_HI:RETRY_SEL_LO])
			2'b00:   retryLimit = CNT_W'(RETRY0_CYC_P);
			2'b01:   retryLimit = CNT_W'(RETRY1_CYC_P);
			2'b10:   retryLimit = CNT_W'(RETRY2_CYC_P);
			default: retryLimit = CNT_W'(RETRY3_CYC_P);
		endcase
	end

	//==========================================================
	// Per-driver blanking: a fault must persist for the whole
	// blanking time before it is signalled
	for (genvar i = 0; i < 2; i++) begin : gBlank
		always_comb begin
			blankCnt_nxt[i] = '0;
			faultHit[i]     = 1'b0;
			if (drvState_r == MLC_DRV_ON
				&& (drvOverCurrent[i] | drvOverTemp[i])) begin
				blankCnt_nxt[i] = blankCnt_r[i] + CNT_W'(1);
				if (blankCnt_nxt[i] >= blankLimit) begin
					faultHit[i]     = 1'b1;
					blankCnt_nxt[i] = '0;
				end
			end
		end

		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				blankCnt_r[i] <= '0;
			end else begin
				blankCnt_r[i] <= blankCnt_nxt[i];
			end
		end
	end

	//==========================================================
	// Driver protection state machine; a fault on either driver
	// turns both off, since they share the retry timer
	always_comb begin
		drvState_nxt = drvState_r;
		offCnt_nxt   = '0;
		case (drvState_r)
			MLC_DRV_ON: begin
				if (|faultHit) begin
					if (autoRetry) begin
						drvState_nxt = MLC_DRV_RETRY;
					end else begin
						drvState_nxt = MLC_DRV_COOL;
					end
				end
			end
			MLC_DRV_RETRY: begin
				offCnt_nxt = offCnt_r + CNT_W'(1);
				if (offCnt_nxt >= retryLimit) begin
					drvState_nxt = MLC_DRV_ON;
					offCnt_nxt   = '0;
				end
			end
			MLC_DRV_COOL: begin
				if (dieCool) begin
					drvState_nxt = MLC_DRV_ON;
				end
			end
			default: begin
				drvState_nxt = MLC_DRV_ON;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			drvState_r <= MLC_DRV_ON;
			offCnt_r   <= '0;
			drvEn_r    <= 2'b11;
		end else begin
			drvState_r <= drvState_nxt;
			offCnt_r   <= offCnt_nxt;
			drvEn_r    <= {2{drvState_nxt == MLC_DRV_ON}};
		end
	end

	//==========================================================
	// Configuration outputs, registered so pins never glitch
	always_comb begin
		outs_nxt[0] = mode_nxt[MODE_WAKE_OFF];
		outs_nxt[1] = mode_nxt[MODE_LDO_OFF];
		outs_nxt[2] = mode_nxt[MODE_SHARE_EN];
		outs_nxt[3] = mode_nxt[MODE_FILT_OFF];
		outs_nxt[4] = mode_nxt[MODE_IND_A]
			| indicatorAInputPin;
		outs_nxt[5] = mode_nxt[MODE_IND_B];
		outs_nxt[6] = limit_nxt[LIM_OFF];
		outs_nxt[7] = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			outs_r      <= 8'h00;
			limitSelect <= 2'b00;
		end else begin
			outs_r      <= outs_nxt;
			limitSelect <= limit_nxt[LIM_SEL_HI:LIM_SEL_LO];
		end
	end

	assign wakeupDetectOff     = outs_r[0];
	assign lowRailRegulatorOff = outs_r[1];
	assign serialShareEnable   = outs_r[2];
	assign rxGlitchFilterOff   = outs_r[3];
	assign indicatorAOutput    = outs_r[4];
	assign indicatorBOutput    = outs_r[5];
	assign limitOff            = outs_r[6];
	assign driverEnable        = drvEn_r;
	assign irqN                = irqN_r;

endmodule : mlc_mode_limit_ctrl

// >>> rtl/mlc_pkg.sv
//==============================================================
// Purpose: Constants for the mode and current-limit register block
// Assumes: 20 MHz core clock, 3-bit register addresses
// Notes:   Times are kept in their own unit, cycles derived here
//==============================================================
package mlc_pkg;

	//==========================================================
	// Register addresses
	localparam logic [2:0] ADDR_INT   = 3'h0;
	localparam logic [2:0] ADDR_STAT  = 3'h1;
	localparam logic [2:0] ADDR_MODE  = 3'h2;
	localparam logic [2:0] ADDR_LIMIT = 3'h3;
	localparam logic [7:0] REG_RESET  = 8'h00;

	//==========================================================
	// Mode register fields
	localparam int MODE_SOFT_RST   = 7;
	localparam int MODE_WAKE_OFF   = 6;
	localparam int MODE_LDO_OFF    = 5;
	localparam int MODE_SHARE_EN   = 4;
	localparam int MODE_WARN_EN    = 3;
	localparam int MODE_FILT_OFF   = 2;
	localparam int MODE_IND_B      = 1;
	localparam int MODE_IND_A      = 0;

	//==========================================================
	// Limit register fields
	localparam int LIM_SEL_HI   = 7;
	localparam int LIM_SEL_LO   = 6;
	localparam int LIM_OFF      = 5;
	localparam int BLANK_SEL_HI = 4;
	localparam int BLANK_SEL_LO = 3;
	localparam int RETRY_SEL_HI = 2;
	localparam int RETRY_SEL_LO = 1;
	localparam int RETRY_EN     = 0;

	//==========================================================
	// Interrupt and status fields
	localparam int INT_DO_FAULT = 5;
	localparam int INT_CQ_FAULT = 4;
	localparam int INT_WARN     = 3;
	localparam int STAT_THERMAL = 7;

	//==========================================================
	// Serial frame
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HEAD_BITS  = 5'h08;

	//==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int BLANK0_US = 128;
	localparam int BLANK1_US = 500;
	localparam int BLANK2_US = 1000;
	localparam int BLANK3_US = 5000;
	localparam int RETRY0_MS = 50;
	localparam int RETRY1_MS = 100;
	localparam int RETRY2_MS = 200;
	localparam int RETRY3_MS = 500;
	localparam int BLANK0_CYC = (BLANK0_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BLANK1_CYC = (BLANK1_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BLANK2_CYC = (BLANK2_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BLANK3_CYC = (BLANK3_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RETRY0_CYC = (RETRY0_MS * 1000000) / CLK_PERIOD_NS;
	localparam int RETRY1_CYC = (RETRY1_MS * 1000000) / CLK_PERIOD_NS;
	localparam int RETRY2_CYC = (RETRY2_MS * 1000000) / CLK_PERIOD_NS;
	localparam int RETRY3_CYC = (RETRY3_MS * 1000000) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	//==========================================================
	// Driver protection states
	typedef enum logic [1:0] {
		MLC_DRV_ON    = 2'b00,
		MLC_DRV_RETRY = 2'b01,
		MLC_DRV_COOL  = 2'b10
	} mlc_drv_e;

endpackage : mlc_pkg

// >>> rtl/mlc_reg_if.sv
//==============================================================
// Purpose: Register access strobes between serial port and bank
// Assumes: One core clock
// Notes:   Strobes are one-cycle pulses
//==============================================================
interface mlc_reg_if;
	logic       wrStb;
	logic       rdStb;
	logic [2:0] addr;
	logic [7:0] wrData;
	logic [7:0] rdData;

	modport port (output wrStb, output rdStb, output addr,
		output wrData, input rdData);
	modport bank (input wrStb, input rdStb, input addr,
		input wrData, output rdData);
endinterface : mlc_reg_if

// >>> rtl/mlc_serial_port.sv
//==============================================================
// Purpose: Serial register port, 16-bit frames, clock mode 0
// Assumes: Pins synchronous to core clock, sclk much slower
// Notes:   Byte 0 = addr[7:5], read flag [0]; byte 1 = data
//==============================================================
module mlc_serial_port
	import mlc_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic csN,
	input  wire logic sclk,
	input  wire logic sdi,
	output logic      sdo,
	output logic      sdoOe,
	mlc_reg_if.port   regs
);
	logic [4:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] rxShift_r, rxShift_nxt;
	logic [7:0] txShift_r, txShift_nxt;
	logic [2:0] addr_r, addr_nxt;
	logic       isRead_r, isRead_nxt;
	logic       sclkLast_r;
	logic       sdo_r, sdo_nxt;
	logic       sdoOe_r;
	logic       wrStb_r, wrStb_nxt;
	logic       rdStb_r, rdStb_nxt;
	logic       rise;
	logic       fall;

	//==========================================================
	// Frame engine
	// Edges are found by comparing with last sample of sclk
	always_comb begin
		rise        = sclk & ~sclkLast_r;
		fall        = ~sclk & sclkLast_r;
		bitCnt_nxt  = bitCnt_r;
		rxShift_nxt = rxShift_r;
		txShift_nxt = txShift_r;
		addr_nxt    = addr_r;
		isRead_nxt  = isRead_r;
		sdo_nxt     = sdo_r;
		wrStb_nxt   = 1'b0;
		rdStb_nxt   = 1'b0;
		if (csN) begin
			// Deselect aborts any partial frame
			bitCnt_nxt = '0;
			sdo_nxt    = 1'b0;
		end else begin
			if (rise && bitCnt_r < FRAME_BITS) begin
				rxShift_nxt = {rxShift_r[6:0], sdi};
				bitCnt_nxt  = bitCnt_r + 5'h01;
				if (bitCnt_r == HEAD_BITS - 5'h01) begin
					addr_nxt   = rxShift_r[6:4];
					isRead_nxt = sdi;
					rdStb_nxt  = sdi;
				end
				if (bitCnt_r == FRAME_BITS - 5'h01) begin
					wrStb_nxt = ~isRead_r;
				end
			end
			// Read data is loaded the cycle after the read strobe
			if (rdStb_r) begin
				txShift_nxt = regs.rdData;
			end
			if (fall && bitCnt_r >= HEAD_BITS
				&& bitCnt_r < FRAME_BITS) begin
				sdo_nxt     = txShift_r[7];
				txShift_nxt = {txShift_r[6:0], 1'b0};
			end
		end
	end

	//==========================================================
	// Frame registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bitCnt_r   <= '0;
			rxShift_r  <= 8'h00;
			txShift_r  <= 8'h00;
			addr_r     <= 3'h0;
			isRead_r   <= 1'b0;
			sclkLast_r <= 1'b0;
			sdo_r      <= 1'b0;
			sdoOe_r    <= 1'b0;
			wrStb_r    <= 1'b0;
			rdStb_r    <= 1'b0;
		end else begin
			bitCnt_r   <= bitCnt_nxt;
			rxShift_r  <= rxShift_nxt;
			txShift_r  <= txShift_nxt;
			addr_r     <= addr_nxt;
			isRead_r   <= isRead_nxt;
			sclkLast_r <= sclk;
			sdo_r      <= sdo_nxt;
			sdoOe_r    <= ~csN;
			wrStb_r    <= wrStb_nxt;
			rdStb_r    <= rdStb_nxt;
		end
	end

	assign regs.wrStb  = wrStb_r;
	assign regs.rdStb  = rdStb_r;
	assign regs.addr   = addr_r;
	assign regs.wrData = rxShift_r;
	assign sdo         = sdo_r;
	assign sdoOe       = sdoOe_r;

endmodule : mlc_serial_port

// >>> tb/mlc_host_model.sv
//==============================================================
// Purpose: Host side of the serial register port
// Assumes: Mode 0 frames, address byte then data byte, MSB first
// Notes:   Serial clock stands still high between frames, low only before the first
//==============================================================
module mlc_host_model (
	input  wire logic core_clk,
	output logic      csN,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ns;

	//==========================================================
	// Idle pins
	initial begin
		csN  = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end

	// Phases of 4 cycles leave margin over the 2-cycle minimum
	task automatic frame(input logic [2:0] addr, input logic rd,
		input logic [7:0] wdat, output logic [7:0] rdat);
		logic [15:0] word;
		word = {addr, 4'h0, rd, wdat};
		rdat = 8'h00;
		@(posedge core_clk) csN <= 1'b0;
		for (int k = 15; k >= 0; k--) begin
			@(posedge core_clk) sclk <= 1'b0;
			sdi <= word[k];
			repeat (3) @(posedge core_clk);
			@(posedge core_clk) sclk <= 1'b1;
			if (k < 8) rdat[k] = sdo;
			repeat (3) @(posedge core_clk);
		end
		// Hold select until the write has landed
		repeat (6) @(posedge core_clk);
		csN <= 1'b1;
		sdi <= ~sdi;
		repeat (2) @(posedge core_clk);
	endtask : frame
endmodule : mlc_host_model

// >>> tb/mlc_monitor.sv
//==============================================================
// Purpose: Port assertions for the mode and current-limit block
// Assumes: Blanking counts shortened to at least 8 cycles
// Notes:   Bound to every instance of the top module
//==============================================================
module mlc_monitor (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       csN,
	input wire logic       sdo,
	input wire logic       sdoOe,
	input wire logic       irqN,
	input wire logic       indicatorAInputPin,
	input wire logic [1:0] drvOverCurrent,
	input wire logic [1:0] drvOverTemp,
	input wire logic       wakeupDetectOff,
	input wire logic       lowRailRegulatorOff,
	input wire logic       serialShareEnable,
	input wire logic       rxGlitchFilterOff,
	input wire logic       indicatorAOutput,
	input wire logic       indicatorBOutput,
	input wire logic [1:0] limitSelect,
	input wire logic       limitOff,
	input wire logic [1:0] driverEnable
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	//==========================================================
	// Assertions
	reset_idle_a: assert property (
		$past(!rst_n) |-> irqN && driverEnable == 2'b11 && !limitOff
			&& limitSelect == 2'b00 && !indicatorBOutput)
		else $error("outputs not idle after reset");
	ind_a_pin_a: assert property (
		$past(rst_n) && $past(indicatorAInputPin) |-> indicatorAOutput)
		else $error("indicator A ignores its input");
	drv_pair_a: assert property (
		driverEnable == 2'b00 || driverEnable == 2'b11)
		else $error("drivers enabled unequally");
	oe_idle_a: assert property (
		csN && $past(csN) |-> !sdoOe && !sdo)
		else $error("serial output active while deselected");
	oe_start_a: assert property (
		$fell(csN) |-> ##[1:3] sdoOe)
		else $error("serial output not enabled in frame");
	// Minimum blanking is 8 cycles, so a cut needs an older fault
	fault_blank_a: assert property (
		$fell(driverEnable[0]) |-> $past(|(drvOverCurrent | drvOverTemp), 4))
		else $error("drivers cut without a lasting fault");
	fault_irq_a: assert property (
		$fell(driverEnable[0]) |-> ##[0:3] !irqN)
		else $error("driver fault raised no interrupt");
	// Settings change only through a frame
	cfg_hold_a: assert property (
		csN && $past(csN) && $past(csN, 2) |-> $stable({limitSelect,
			limitOff, wakeupDetectOff, lowRailRegulatorOff,
			serialShareEnable, rxGlitchFilterOff, indicatorBOutput}))
		else $error("settings changed outside a frame");

	//==========================================================
	// Coverage of the main scenarios
	cover property ($fell(driverEnable[0]));
	cover property ($rose(driverEnable[0]));
	cover property ($fell(irqN));
endmodule : mlc_monitor

bind mlc_mode_limit_ctrl mlc_monitor mlc_monitor_inst (.core_clk, .rst_n,
	.csN, .sdo, .sdoOe, .irqN, .indicatorAInputPin, .drvOverCurrent,
	.drvOverTemp, .wakeupDetectOff, .lowRailRegulatorOff,
	.serialShareEnable, .rxGlitchFilterOff, .indicatorAOutput,
	.indicatorBOutput, .limitSelect, .limitOff, .driverEnable);

// >>> tb/tb_top.sv
//==============================================================
// Purpose: Self-checking bench for the mode and limit block
// Assumes: Shortened blanking 8..64 and retry 50..500 cycles
// Notes:   Outputs are sampled on the falling clock edge in waits, on the rising edge after frames
//==============================================================
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mlc_pkg::*;

	logic       core_clk, rst_n, csN, sclk, sdi, sdo, sdoOe, irqN;
	logic       indicatorAInputPin, fieldSupplyLow, dieCool;
	logic [1:0] drvOverCurrent, drvOverTemp, limitSelect, driverEnable;
	logic       wakeupDetectOff, lowRailRegulatorOff, serialShareEnable;
	logic       rxGlitchFilterOff, indicatorAOutput, indicatorBOutput;
	logic       limitOff;
	int         mismatches, num_checks;
	wire logic [7:0] cfgOut = {1'b0, wakeupDetectOff, lowRailRegulatorOff,
		serialShareEnable, 1'b0, rxGlitchFilterOff, indicatorBOutput,
		indicatorAOutput};
	wire logic [7:0] limOut = {limitSelect, limitOff, 5'h00};

	mlc_mode_limit_ctrl #(.BLANK0_CYC_P(8), .BLANK1_CYC_P(16),
		.BLANK2_CYC_P(32), .BLANK3_CYC_P(64), .RETRY0_CYC_P(50),
		.RETRY1_CYC_P(100), .RETRY2_CYC_P(200), .RETRY3_CYC_P(500))
	mlc_mode_limit_ctrl_inst (.core_clk, .rst_n, .csN, .sclk, .sdi, .sdo,
		.sdoOe, .irqN, .indicatorAInputPin, .fieldSupplyLow,
		.drvOverCurrent, .drvOverTemp, .dieCool, .wakeupDetectOff,
		.lowRailRegulatorOff, .serialShareEnable, .rxGlitchFilterOff,
		.indicatorAOutput, .indicatorBOutput, .limitSelect, .limitOff,
		.driverEnable);

	mlc_host_model mlc_host_model_inst (.core_clk, .csN, .sclk, .sdi,
		.sdo);

	//==========================================================
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	//==========================================================
	// Shared tasks
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] x;
		mlc_host_model_inst.frame(a, 1'b0, d, x);
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		mlc_host_model_inst.frame(a, 1'b1, 8'h00, d);
	endtask : rd

	// Bounded wait on the driver enables; n counts cycles waited
	task automatic wait_de(input logic [1:0] v, input int lim,
		output int n);
		n = 0;
		while (driverEnable !== v) begin
			@(negedge core_clk);
			n++;
			if (n > lim) begin
				mismatches++;
				$display("[ERR] driverEnable expected %h seen %h", v,
					driverEnable);
				print_verdict();
			end
		end
	endtask : wait_de

	//==========================================================
	// Main sequence
	initial begin
		logic [7:0] d;
		int n;
		int bl;
		int rtab[4] = '{50, 100, 200, 500};
		rst_n = 1'b0;
		indicatorAInputPin = 1'b0;
		fieldSupplyLow = 1'b0;
		dieCool = 1'b0;
		drvOverCurrent = 2'b00;
		drvOverTemp = 2'b00;
		mismatches = 0;
		num_checks = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(ADDR_MODE, d);
		chk("mode reset", d, REG_RESET);
		rd(ADDR_LIMIT, d);
		chk("limit reset", d, REG_RESET);
		// Each mode bit but soft reset alone, read twice to show reads are harmless
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_MODE, 8'h01 << i);
			rd(ADDR_MODE, d);
			rd(ADDR_MODE, d);
			chk("mode reread", d, 8'h01 << i);
			chk("mode outputs", cfgOut, (8'h01 << i) & 8'h77);
		end
		wr(ADDR_MODE, 8'h00);
		@(posedge core_clk) indicatorAInputPin <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk("indicator A pin", cfgOut, 8'h01);
		@(posedge core_clk) indicatorAInputPin <= 1'b0;
		// Every limit select with the limit on and off
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_LIMIT, {i[2:0], 5'h00});
			rd(ADDR_LIMIT, d);
			chk("limit readback", d, {i[2:0], 5'h00});
			chk("limit outputs", limOut, {i[2:0], 5'h00});
		end
		// Unmapped address: write dropped, read zero
		wr(3'h7, 8'hA5);
		rd(3'h7, d);
		chk("unmapped read", d, 8'h00);
		rd(ADDR_MODE, d);
		chk("mode after unmapped", d, 8'h00);
		// Supply warning masked, then enabled and sticky until read
		@(posedge core_clk) fieldSupplyLow <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk("warn masked", {7'h00, irqN}, 8'h01);
		wr(ADDR_MODE, 8'h08);
		chk("warn irq", {7'h00, irqN}, 8'h00);
		@(posedge core_clk) fieldSupplyLow <= 1'b0;
		rd(ADDR_INT, d);
		chk("warn flag", d & 8'h08, 8'h08);
		rd(ADDR_INT, d);
		chk("flags after read", d, 8'h00);
		chk("irq after read", {7'h00, irqN}, 8'h01);
		// Soft reset while an interrupt is pending
		wr(ADDR_LIMIT, 8'hFF);
		@(posedge core_clk) fieldSupplyLow <= 1'b1;
		wr(ADDR_MODE, 8'h80);
		chk("irq soft reset", {7'h00, irqN}, 8'h01);
		rd(ADDR_MODE, d);
		chk("mode soft reset", d, 8'h00);
		rd(ADDR_LIMIT, d);
		chk("limit soft reset", d, 8'h00);
		chk("limit out reset", limOut, 8'h00);
		rd(ADDR_INT, d);
		chk("flags soft reset", d, 8'h00);
		@(posedge core_clk) fieldSupplyLow <= 1'b0;
		// Auto-retry on each driver and fault kind, each timing select
		for (int i = 0; i < 4; i++) begin
			bl = 8 << i;
			wr(ADDR_LIMIT, {3'h0, i[1:0], i[1:0], 1'b1});
			@(posedge core_clk);
			drvOverCurrent <= i[1] ? 2'b00 : 2'b01 << i[0];
			drvOverTemp <= i[1] ? 2'b01 << i[0] : 2'b00;
			wait_de(2'b00, 80, n);
			chk("blank time", {7'h00, n >= bl && n <= bl + 4}, 8'h01);
			@(posedge core_clk) drvOverCurrent <= 2'b00;
			drvOverTemp <= 2'b00;
			wait_de(2'b11, 600, n);
			chk("off time", {7'h00, n >= rtab[i] - 2 && n <= rtab[i] + 4},
				8'h01);
			rd(ADDR_INT, d);
			chk("fault flag", d & 8'h30, 8'h10 << i[0]);
		end
		// Without retry the drivers wait for the die to cool
		wr(ADDR_LIMIT, 8'h00);
		@(posedge core_clk) drvOverTemp <= 2'b01;
		wait_de(2'b00, 20, n);
		@(posedge core_clk) drvOverTemp <= 2'b00;
		repeat (600) @(negedge core_clk);
		chk("held off", {6'h00, driverEnable}, 8'h00);
		@(posedge core_clk) dieCool <= 1'b1;
		wait_de(2'b11, 8, n);
		chk("cool restart", {6'h00, driverEnable}, 8'h03);
		print_verdict();
	end
endmodule : tb_top
